// File: pkg/core_status_defines.svh
`ifndef CORE_STATUS_DEFINES_SVH
`define CORE_STATUS_DEFINES_SVH

// APB register byte addresses
`define CSF_ADDR_STATUS 8'h00
`define CSF_ADDR_IRQ_STATUS 8'h04
`define CSF_ADDR_IRQ_MASK 8'h08
`define CSF_ADDR_PROG_ADDR 8'h0c

// Bit positions inside the status flags register
`define CSF_BIT_PIN_WAKE 7
`define CSF_BIT_CMP_WAKE 6
`define CSF_BIT_PAGE 5
`define CSF_BIT_TIMEOUT 4
`define CSF_BIT_POWERDOWN 3
`define CSF_BIT_ZERO 2
`define CSF_BIT_DIGIT_CARRY 1
`define CSF_BIT_CARRY 0

// Bits that software may write in the status flags register
`define CSF_SW_WRITE_MASK 8'he7

// Reset values
`define CSF_RST_TIMEOUT 1'b1
`define CSF_RST_POWERDOWN 1'b1
`define CSF_RST_WAKE 1'b0
`define CSF_RST_PAGE 1'b0
`define CSF_RST_IRQ_STATUS 4'h0
`define CSF_RST_IRQ_MASK 4'h0

// Interrupt status bit positions
`define CSF_IRQ_TIMEOUT 0
`define CSF_IRQ_SLEEP 1
`define CSF_IRQ_PIN_WAKE 2
`define CSF_IRQ_CMP_WAKE 3
`define CSF_IRQ_COUNT 4

// Program address in-page width, and ALU nibble width for the digit carry
`define CSF_PAGE_ADDR_BITS 9
`define CSF_NIBBLE_BITS 4

`endif

// File: pkg/core_status_pkg.sv
package core_status_pkg;

  // Operation presented by the core's execute stage
  typedef enum logic [2:0] {
    ALU_NONE = 3'h0,
    ALU_ADD_W_FILE = 3'h1,
    ALU_SUB_W_FILE = 3'h2,
    ALU_LOGIC = 3'h3,
    ALU_ROTATE_RIGHT = 3'h4,
    ALU_ROTATE_LEFT = 3'h5
  } alu_op_t;

  // One ALU request: file operand, working register, and result of a logic op
  typedef struct packed {
    alu_op_t op;
    logic [7:0] file_val;
    logic [7:0] w_val;
    logic [7:0] logic_result;
  } alu_req_t;

  // Core events, each a one-cycle pulse
  typedef struct packed {
    logic clear_watchdog_instr;
    logic sleep_instr;
    logic wdt_timeout;
    logic other_reset;
    logic pin_wake_reset;
    logic cmp_wake_reset;
  } core_event_t;

  // Flag bits as they sit in the register, bit 7 first
  typedef struct packed {
    logic pin_change_wake_flag;
    logic comparator_wake_flag;
    logic page_preselect;
    logic timeout_flag;
    logic powerdown_flag;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } status_flags_t;

endpackage

// File: hw/cpu_status_flags.sv
`timescale 1ns/1ps
`include "core_status_defines.svh"

// What this block does
// - Page preselect bit 5: one selects 200h-3FFh, zero selects 000h-1FFh.
// - Pages span 512 locations; preselect is the bit above nine in-page bits.
// - Time-out flag set by power-up, clear-watchdog, sleep; cleared by watchdog time-out.
// - Power-down flag set by power-up and by the clear-watchdog instruction.
// - Power-down flag cleared by the sleep instruction.
// - Zero flag follows arithmetic or logic result: one when zero, else zero.
// - Digit carry changes only on add or subtract of working and file register, or on a software write.
// - Digit carry is nibble carry for add, inverted nibble borrow for subtract.
module cpu_status_flags #(
  parameter int PAGE_ADDR_BITS = `CSF_PAGE_ADDR_BITS
) (
  input wire logic ref_clk, // 10 MHz core clock
  input wire logic rst_b, // Power-on reset, synchronous, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  input wire core_status_pkg::alu_req_t alu_req, // ALU request from core
  input wire core_status_pkg::core_event_t core_event, // Core event pulses
  input wire logic [PAGE_ADDR_BITS-1:0] in_page_addr, // Address within page
  output core_status_pkg::status_flags_t status_flags, // Live flag bits
  output logic [7:0] alu_result, // Result of the last ALU request
  output logic [PAGE_ADDR_BITS:0] prog_addr, // Full program address
  output logic irq // Level interrupt
);

  // Address decode is used by both the read and the write path
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    addr_is = (addr == target);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = addr_is(addr, `CSF_ADDR_STATUS) || addr_is(addr, `CSF_ADDR_IRQ_STATUS) ||
                  addr_is(addr, `CSF_ADDR_IRQ_MASK) || addr_is(addr, `CSF_ADDR_PROG_ADDR);
  endfunction

  // Access phase write strobe: the single edge at which a write takes effect
  logic wr_access;
  logic [7:0] wr_byte;
  assign wr_access = psel && penable && pready && pwrite;
  assign wr_byte = pwdata[7:0];

  // ---------------- Status flags ----------------
  core_status_pkg::status_flags_t next_status_flags;
  logic [7:0] next_alu_result;
  logic [4:0] nib_sum;
  logic [8:0] byte_sum;
  logic [7:0] op_result;
  logic alu_active;

  // Next flag values; hardware updates come after a software write so they win
  always_comb begin
    next_status_flags = status_flags;
    next_alu_result = alu_result;
    nib_sum = 5'h00;
    byte_sum = 9'h000;
    op_result = 8'h00;
    alu_active = 1'b0;

    // Software write: time-out and power-down are masked off as read-only
    if (wr_access && addr_is(paddr, `CSF_ADDR_STATUS)) begin
      next_status_flags = core_status_pkg::status_flags_t'(
        (status_flags & ~`CSF_SW_WRITE_MASK) | (wr_byte & `CSF_SW_WRITE_MASK));
    end

    // ALU flag updates
    unique case (alu_req.op)
      core_status_pkg::ALU_ADD_W_FILE: begin
        nib_sum = {1'b0, alu_req.file_val[3:0]} + {1'b0, alu_req.w_val[3:0]};
        byte_sum = {1'b0, alu_req.file_val} + {1'b0, alu_req.w_val};
        op_result = byte_sum[7:0];
        alu_active = 1'b1;
        next_status_flags.digit_carry_flag = nib_sum[`CSF_NIBBLE_BITS];
        next_status_flags.carry_flag = byte_sum[8];
      end
      core_status_pkg::ALU_SUB_W_FILE: begin
        // Subtract as file plus two's complement of W: carry out is the inverted borrow
        nib_sum = {1'b0, alu_req.file_val[3:0]} + {1'b0, ~alu_req.w_val[3:0]} + 5'h01;
        byte_sum = {1'b0, alu_req.file_val} + {1'b0, ~alu_req.w_val} + 9'h001;
        op_result = byte_sum[7:0];
        alu_active = 1'b1;
        next_status_flags.digit_carry_flag = nib_sum[`CSF_NIBBLE_BITS];
        next_status_flags.carry_flag = byte_sum[8];
      end
      core_status_pkg::ALU_LOGIC: begin
        op_result = alu_req.logic_result;
        alu_active = 1'b1;
      end
      core_status_pkg::ALU_ROTATE_RIGHT: begin
        // Rotate through carry: old carry enters, LSb leaves; zero flag untouched
        next_alu_result = {status_flags.carry_flag, alu_req.file_val[7:1]};
        next_status_flags.carry_flag = alu_req.file_val[0];
      end
      core_status_pkg::ALU_ROTATE_LEFT: begin
        next_alu_result = {alu_req.file_val[6:0], status_flags.carry_flag};
        next_status_flags.carry_flag = alu_req.file_val[7];
      end
      default: begin
        // No operation, or an illegal code: flags hold
      end
    endcase

    if (alu_active) begin
      next_alu_result = op_result;
      next_status_flags.zero_flag = (op_result == 8'h00);
    end

    // Clear-watchdog and sleep instructions
    if (core_event.clear_watchdog_instr) begin
      next_status_flags.timeout_flag = 1'b1;
      next_status_flags.powerdown_flag = 1'b1;
    end
    if (core_event.sleep_instr) begin
      next_status_flags.timeout_flag = 1'b1;
      next_status_flags.powerdown_flag = 1'b0;
    end
    // A watchdog time-out beats an instruction in the same cycle: it is the rarer, harder event
    if (core_event.wdt_timeout) begin
      next_status_flags.timeout_flag = 1'b0;
    end

    // Device resets other than power-on: time-out and power-down survive them
    if (core_event.other_reset || core_event.pin_wake_reset || core_event.cmp_wake_reset) begin
      next_status_flags.pin_change_wake_flag = core_event.pin_wake_reset;
      next_status_flags.comparator_wake_flag = core_event.cmp_wake_reset;
      next_status_flags.page_preselect = `CSF_RST_PAGE;
    end
  end

  // Control bits take the power-on value; the ALU flags and result are deliberately left without reset.
  // One process owns the whole flag register, so no field of it has a second driver.
  always_ff @(posedge ref_clk) begin
    status_flags.zero_flag <= next_status_flags.zero_flag;
    status_flags.digit_carry_flag <= next_status_flags.digit_carry_flag;
    status_flags.carry_flag <= next_status_flags.carry_flag;
    alu_result <= next_alu_result;
    if (!rst_b) begin
      status_flags.pin_change_wake_flag <= `CSF_RST_WAKE;
      status_flags.comparator_wake_flag <= `CSF_RST_WAKE;
      status_flags.page_preselect <= `CSF_RST_PAGE;
      status_flags.timeout_flag <= `CSF_RST_TIMEOUT;
      status_flags.powerdown_flag <= `CSF_RST_POWERDOWN;
    end else begin
      status_flags.pin_change_wake_flag <= next_status_flags.pin_change_wake_flag;
      status_flags.comparator_wake_flag <= next_status_flags.comparator_wake_flag;
      status_flags.page_preselect <= next_status_flags.page_preselect;
      status_flags.timeout_flag <= next_status_flags.timeout_flag;
      status_flags.powerdown_flag <= next_status_flags.powerdown_flag;
    end
  end

  // ---------------- Program address ----------------
  logic [PAGE_ADDR_BITS:0] next_prog_addr;

  // Page bit sits directly above the in-page address; uses the bit already stored
  always_comb begin
    next_prog_addr = {status_flags.page_preselect, in_page_addr};
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prog_addr <= '0;
    end else begin
      prog_addr <= next_prog_addr;
    end
  end

  // ---------------- Interrupt status and mask ----------------
  logic [`CSF_IRQ_COUNT-1:0] irq_status;
  logic [`CSF_IRQ_COUNT-1:0] irq_mask;
  logic [`CSF_IRQ_COUNT-1:0] irq_event;
  logic [`CSF_IRQ_COUNT-1:0] next_irq_status;
  logic [`CSF_IRQ_COUNT-1:0] next_irq_mask;
  logic next_irq;
  logic clr_strobe;

  assign irq_event[`CSF_IRQ_TIMEOUT] = core_event.wdt_timeout;
  assign irq_event[`CSF_IRQ_SLEEP] = core_event.sleep_instr;
  assign irq_event[`CSF_IRQ_PIN_WAKE] = core_event.pin_wake_reset;
  assign irq_event[`CSF_IRQ_CMP_WAKE] = core_event.cmp_wake_reset;
  assign clr_strobe = wr_access && addr_is(paddr, `CSF_ADDR_IRQ_STATUS);

  // Sticky bits: write one to clear, and an event in the clear cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < `CSF_IRQ_COUNT; gi++) begin : g_irq
      always_comb begin
        next_irq_status[gi] = irq_status[gi];
        if (clr_strobe && wr_byte[gi]) begin
          next_irq_status[gi] = 1'b0;
        end
        if (irq_event[gi]) begin
          next_irq_status[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // Mask write and the combined level; irq lags the status bit by one cycle
  always_comb begin
    next_irq_mask = irq_mask;
    if (wr_access && addr_is(paddr, `CSF_ADDR_IRQ_MASK)) begin
      next_irq_mask = wr_byte[`CSF_IRQ_COUNT-1:0];
    end
    next_irq = |(irq_status & irq_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_status <= `CSF_RST_IRQ_STATUS;
      irq_mask <= `CSF_RST_IRQ_MASK;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

  // ---------------- APB slave ----------------
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic setup_phase;

  assign setup_phase = psel && !penable;

  // Read data, ready and error are prepared in the setup cycle so every output is a flop;
  // the transfer still completes in its first access cycle, with zero wait states
  always_comb begin
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (setup_phase) begin
      next_pready = 1'b1;
      next_pslverr = !addr_mapped(paddr);
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (addr_is(paddr, `CSF_ADDR_STATUS)) begin
          next_prdata = {24'h00_0000, status_flags};
        end else if (addr_is(paddr, `CSF_ADDR_IRQ_STATUS)) begin
          next_prdata = {28'h000_0000, irq_status};
        end else if (addr_is(paddr, `CSF_ADDR_IRQ_MASK)) begin
          next_prdata = {28'h000_0000, irq_mask};
        end else if (addr_is(paddr, `CSF_ADDR_PROG_ADDR)) begin
          next_prdata = {{(31-PAGE_ADDR_BITS){1'b0}}, prog_addr};
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

// File: dv/cpu_status_flags_sva.sv
`timescale 1ns/1ps
module cpu_status_flags_sva #(
  parameter int PAGE_ADDR_BITS = 9
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire core_status_pkg::alu_req_t alu_req, // ALU request
  input wire core_status_pkg::core_event_t core_event, // Events
  input wire logic [PAGE_ADDR_BITS-1:0] in_page_addr, // In-page address
  input wire core_status_pkg::status_flags_t status_flags, // Flags
  input wire logic [PAGE_ADDR_BITS:0] prog_addr // Program address
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Reference sums; a same-cycle software write may legally move untouched bits
  logic [8:0] sum;
  logic nib_c;
  logic sw_wr;
  assign sum = {1'b0, alu_req.file_val} + {1'b0, alu_req.w_val};
  assign nib_c = (alu_req.file_val[3:0] + alu_req.w_val[3:0]) > 5'h0f;
  assign sw_wr = psel & penable & pwrite;
  sequence s_sleep;
    core_event.sleep_instr && !core_event.wdt_timeout;
  endsequence
  sequence s_asleep;
    status_flags.timeout_flag && !status_flags.powerdown_flag;
  endsequence
  property p_sleep;
    s_sleep |=> s_asleep;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep flags wrong");
  property p_clr;
    core_event.clear_watchdog_instr && !core_event.sleep_instr && !core_event.wdt_timeout
      |=> status_flags.timeout_flag && status_flags.powerdown_flag;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear watchdog flags wrong");
  property p_wdt;
    core_event.wdt_timeout |=> !status_flags.timeout_flag;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("timeout flag not cleared");
  property p_wake;
    core_event.pin_wake_reset || core_event.cmp_wake_reset || core_event.other_reset
      |=> {status_flags.pin_change_wake_flag, status_flags.comparator_wake_flag}
      == $past({core_event.pin_wake_reset, core_event.cmp_wake_reset});
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake flags wrong");
  property p_page;
    $past(rst_b) |-> prog_addr == {$past(status_flags.page_preselect), $past(in_page_addr)};
  endproperty
  a_page: assert property (p_page)
    else $error("program address wrong");
  property p_add;
    alu_req.op == core_status_pkg::ALU_ADD_W_FILE |=> status_flags.carry_flag == $past(sum[8])
      && status_flags.digit_carry_flag == $past(nib_c) && status_flags.zero_flag == ($past(sum[7:0]) == 8'h00);
  endproperty
  a_add: assert property (p_add)
    else $error("add flags wrong");
  property p_sub;
    alu_req.op == core_status_pkg::ALU_SUB_W_FILE
      |=> status_flags.carry_flag == $past(alu_req.file_val >= alu_req.w_val)
      && status_flags.digit_carry_flag == $past(alu_req.file_val[3:0] >= alu_req.w_val[3:0]);
  endproperty
  a_sub: assert property (p_sub)
    else $error("subtract flags wrong");
  property p_logic;
    alu_req.op == core_status_pkg::ALU_LOGIC && !sw_wr |=> $stable(status_flags.digit_carry_flag)
      && status_flags.zero_flag == ($past(alu_req.logic_result) == 8'h00);
  endproperty
  a_logic: assert property (p_logic)
    else $error("logic flags wrong");
  property p_rot;
    (alu_req.op == core_status_pkg::ALU_ROTATE_RIGHT || alu_req.op == core_status_pkg::ALU_ROTATE_LEFT) && !sw_wr
      |=> $stable(status_flags.zero_flag) && status_flags.carry_flag
      == $past(alu_req.op == core_status_pkg::ALU_ROTATE_LEFT ? alu_req.file_val[7] : alu_req.file_val[0]);
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotate carry wrong");
endmodule

bind cpu_status_flags cpu_status_flags_sva #(.PAGE_ADDR_BITS(PAGE_ADDR_BITS)) cpu_status_flags_sva_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .alu_req(alu_req), .core_event(core_event), .in_page_addr(in_page_addr),
  .status_flags(status_flags), .prog_addr(prog_addr));

// File: dv/cpu_status_flags_test.sv
`timescale 1ns/1ps
module cpu_status_flags_test;
  logic ref_clk;
  logic rst_b;
  logic psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr, alu_result;
  logic [31:0] pwdata, prdata, rd;
  core_status_pkg::alu_req_t alu_req;
  core_status_pkg::core_event_t core_event;
  core_status_pkg::status_flags_t status_flags;
  logic [8:0] in_page_addr;
  logic [9:0] prog_addr;
  int fail_count, checked, cyc;
  // ALU rows: op, file, w, logic result, expected result, expected {z, dc, c}
  logic [37:0] tab [10] = '{{3'h1, 8'h0f, 8'h01, 8'h00, 8'h10, 3'h2}, {3'h1, 8'hff, 8'h01, 8'h00, 8'h00, 3'h7},
    {3'h2, 8'h10, 8'h01, 8'h00, 8'h0f, 3'h1}, {3'h2, 8'h05, 8'h05, 8'h00, 8'h00, 3'h7},
    {3'h2, 8'h00, 8'h10, 8'h00, 8'hf0, 3'h2}, {3'h3, 8'h00, 8'h00, 8'h00, 8'h00, 3'h6},
    {3'h4, 8'h01, 8'h00, 8'h00, 8'h00, 3'h7}, {3'h5, 8'h00, 8'h00, 8'h00, 8'h01, 3'h6},
    {3'h3, 8'h00, 8'h00, 8'h5a, 8'h5a, 3'h2}, {3'h5, 8'h80, 8'h00, 8'h00, 8'h00, 3'h3}};
  // Event rows: pulse, expected flags 7..3
  logic [10:0] ev [7] = '{{6'h10, 5'h06}, {6'h08, 5'h04}, {6'h20, 5'h07}, {6'h02, 5'h13},
    {6'h01, 5'h0b}, {6'h04, 5'h03}, {6'h38, 5'h00}};

  cpu_status_flags cpu_status_flags_i (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu_req(alu_req), .core_event(core_event), .in_page_addr(in_page_addr), .status_flags(status_flags),
    .alu_result(alu_result), .prog_addr(prog_addr), .irq(irq));

  // Clock
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard; the whole run needs fewer than a hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test;
    end
  end

  // APB transfer; the request stands until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n == 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic evt(input logic [5:0] e);
    @(posedge ref_clk);
    core_event <= e;
    @(posedge ref_clk);
    core_event <= 6'h00;
    @(negedge ref_clk);
  endtask

  initial begin
    rst_b = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    alu_req = 27'h0;
    core_event = 6'h00;
    in_page_addr = 9'h1ab;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'h1;
    xfer(1'h0, 8'h00, 32'h0);
    chk("status_rst", 32'h18, rd & 32'hf8);
    xfer(1'h0, 8'h08, 32'h0);
    chk("mask_rst", 32'h0, rd);
    xfer(1'h0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {rd[31:1], err});
    // Back-to-back style ALU sequence; carry chains through the rotates
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      alu_req <= tab[i][37:11];
      @(posedge ref_clk);
      alu_req.op <= core_status_pkg::ALU_NONE;
      @(negedge ref_clk);
      chk("alu_result", tab[i][10:3], alu_result);
      chk("alu_flags", tab[i][2:0], status_flags[2:0]);
    end
    // An illegal op code must leave result and flags alone
    @(posedge ref_clk);
    alu_req <= {3'h7, 8'hff, 8'h01, 8'h00};
    @(posedge ref_clk);
    alu_req.op <= core_status_pkg::ALU_NONE;
    @(negedge ref_clk);
    chk("illegal_op", 32'h003, {alu_result, status_flags[2:0]});
    xfer(1'h1, 8'h00, 32'h20);
    xfer(1'h1, 8'h0c, 32'h0);
    xfer(1'h0, 8'h0c, 32'h0);
    chk("prog_addr", 32'h3ab, rd);
    chk("prog_addr_pin", 32'h3ab, prog_addr);
    for (int i = 0; i < 7; i++) begin
      evt(ev[i][10:5]);
      chk("flags", ev[i][4:0], status_flags[7:3]);
    end
    xfer(1'h0, 8'h04, 32'h0);
    chk("irq_status", 32'hf, rd);
    chk("irq_masked", 32'h0, irq);
    xfer(1'h1, 8'h08, 32'h2);
    xfer(1'h0, 8'h08, 32'h0);
    chk("mask_rb", 32'h2, rd);
    chk("irq_on", 32'h1, irq);
    xfer(1'h1, 8'h04, 32'h2);
    xfer(1'h0, 8'h04, 32'h0);
    chk("irq_w1c", 32'hd, rd);
    chk("irq_off", 32'h0, irq);
    xfer(1'h1, 8'h00, 32'hff);
    xfer(1'h0, 8'h00, 32'h0);
    chk("status_ro", 32'he7, rd);
    // Power-on reset in mid-run: time-out and power-down go from zero back to one
    @(posedge ref_clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'h1;
    xfer(1'h0, 8'h00, 32'h0);
    chk("status_rst2", 32'h18, rd & 32'hf8);
    xfer(1'h0, 8'h08, 32'h0);
    chk("mask_rst2", 32'h0, rd);
    end_of_test;
  end
endmodule
